/* File: common/fvp_defines.svh */
/*
 * Timing counts and command codes for the flash verify/abort host sequencer.
 * Assumes a 40 MHz system clock; the write counts are derived from it, the read wait is a fixed 5 cycles.
 */
`ifndef FVP_DEFINES_SVH
`define FVP_DEFINES_SVH

`define FVP_CLK_NS          25
`define FVP_CMD_READ        16'h0000
`define FVP_CMD_PROGRAM     16'h0040
`define FVP_CMD_VERIFY      16'h00C0
`define FVP_CMD_RESET       16'h00FF
// Write cycle minimum (slower grade), strobe low and high widths in ns
`define FVP_T_WC_NS         120
`define FVP_T_WP_NS         40
`define FVP_T_WPH_NS        20
// Write recovery before read, in us
`define FVP_T_WR_US         6
`define FVP_WP_CYC          ((`FVP_T_WP_NS + `FVP_CLK_NS - 1) / `FVP_CLK_NS)
`define FVP_WPH_CYC         ((`FVP_T_WC_NS - `FVP_T_WP_NS + `FVP_CLK_NS - 1) / `FVP_CLK_NS)
`define FVP_WR_CYC          ((`FVP_T_WR_US * 1000 + `FVP_CLK_NS - 1) / `FVP_CLK_NS)
`define FVP_RD_CYC          5
`define FVP_RETRY_MAX       8'h19

`endif

/* File: common/fvp_pkg.sv */
/*
 * Types for the flash verify/abort host sequencer.
 * Assumes fvp_defines.svh is available on the include path.
 */
package fvp_pkg;

   typedef enum logic [1:0] {
      FVP_OP_PROGRAM,
      FVP_OP_ABORT,
      FVP_OP_READ_MODE
   } fvp_op_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } fvp_word_type;

endpackage

/* File: hdl/fvp_host.sv */
/*
 * Host-side sequencer driving a 16-bit command-driven flash through its pins.
 * Assumes the flash sits on a single-chip bus with its supply already up; the host raises
 * the program voltage through O_VPP_EN for each operation; the pin inputs arrive asynchronously and are resynchronised.
 */
// Summary of operation
// - Verify starts by writing C0 command; flash then verifies last programmed word.
// - Host runs a verify read after every single word program.
// - Two consecutive writes of FF abort any program or erase.
// - Host waits at least 6 us after a write before any read.
// - Program is command 40 then a write with address and data.
// - Writing 00 returns flash to standard read mode.
`timescale 1ns/1ps
`include "fvp_defines.svh"

module fvp_host (
   // Clock and reset
   input  wire logic              I_CLK,
   input  wire logic              I_RST_B,
   // Request side
   input  wire logic              I_REQ,
   input  wire fvp_pkg::fvp_op_type I_OP,
   input  wire fvp_pkg::fvp_word_type I_WORD,
   output logic                   O_BUSY,
   output logic                   O_DONE,
   output logic                   O_FAIL,
   // Flash pins
   output logic                   O_CE_B,
   output logic                   O_OE_B,
   output logic                   O_WE_B,
   output logic                   O_VPP_EN,
   output logic [15:0]            O_ADDR,
   output logic [15:0]            O_DQ,
   output logic                   O_DQ_OE_B,
   input  wire logic [15:0]       I_DQ
);

   typedef enum logic [3:0] {
      S_IDLE, S_WLOW, S_WHIGH, S_RECOVER, S_RDWAIT, S_CHECK, S_FIN
   } fvp_state_type;

   fvp_state_type  state;
   fvp_pkg::fvp_op_type op;
   fvp_pkg::fvp_word_type word;
   logic [2:0]     step;        // Index of the write within the operation
   logic [7:0]     tries;
   logic [15:0]    timer;
   logic [15:0]    dq_meta;
   logic [15:0]    dq_sync;

   // Two-stage resynchroniser for the returned data bus
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else begin
         dq_meta <= I_DQ;
         dq_sync <= dq_meta;
      end
   end

   // Data driven for write number step of the current operation
   function automatic logic [15:0] wr_data(input fvp_pkg::fvp_op_type o,
                                          input logic [2:0] s,
                                          input logic [15:0] d);
      logic [15:0] r;
      r = `FVP_CMD_READ;
      unique case (o)
         fvp_pkg::FVP_OP_PROGRAM: begin
            if (s == 3'h0) begin
               r = `FVP_CMD_PROGRAM;
            end else if (s == 3'h1) begin
               r = d;
            end else begin
               r = `FVP_CMD_VERIFY;
            end
         end
         fvp_pkg::FVP_OP_ABORT: r = `FVP_CMD_RESET;
         fvp_pkg::FVP_OP_READ_MODE: r = `FVP_CMD_READ;
         default: r = `FVP_CMD_READ;
      endcase
      return r;
   endfunction

   // Last write index per operation: program has three, abort two, read one
   function automatic logic [2:0] last_step(input fvp_pkg::fvp_op_type o);
      logic [2:0] r;
      r = 3'h0;
      if (o == fvp_pkg::FVP_OP_PROGRAM) begin
         r = 3'h2;
      end else if (o == fvp_pkg::FVP_OP_ABORT) begin
         r = 3'h1;
      end
      return r;
   endfunction

   // Sequencer: strobes WE with CE low and OE high, so writes are never inhibited
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state     <= S_IDLE;
         op        <= fvp_pkg::FVP_OP_READ_MODE;
         word      <= '0;
         step      <= 3'h0;
         tries     <= 8'h00;
         timer     <= 16'h0000;
         O_BUSY    <= 1'b0;
         O_DONE    <= 1'b0;
         O_FAIL    <= 1'b0;
         O_CE_B    <= 1'b1;
         O_OE_B    <= 1'b1;
         O_WE_B    <= 1'b1;
         O_VPP_EN  <= 1'b0;
         O_ADDR    <= 16'h0000;
         O_DQ      <= 16'h0000;
         O_DQ_OE_B <= 1'b1;
      end else begin
         O_DONE <= 1'b0;
         unique case (state)
            S_IDLE: begin
               O_CE_B    <= 1'b1;
               O_OE_B    <= 1'b1;
               O_DQ_OE_B <= 1'b1;
               if (I_REQ) begin
                  op       <= I_OP;
                  word     <= I_WORD;
                  step     <= 3'h0;
                  tries    <= 8'h00;
                  O_BUSY   <= 1'b1;
                  O_FAIL   <= 1'b0;
                  O_VPP_EN <= 1'b1;
                  state    <= S_WHIGH;
                  timer    <= 16'(`FVP_WPH_CYC);
               end
            end
            S_WHIGH: begin
               // Strobe-high phase pads each cycle to the full write cycle time
               O_CE_B    <= 1'b0;
               O_OE_B    <= 1'b1;
               O_DQ_OE_B <= 1'b0;
               O_ADDR    <= word.addr;
               O_DQ      <= wr_data(op, step, word.data);
               if (timer > 16'h0001) begin
                  timer <= timer - 16'h0001;
               end else begin
                  O_WE_B <= 1'b0;
                  timer  <= 16'(`FVP_WP_CYC);
                  state  <= S_WLOW;
               end
            end
            S_WLOW: begin
               if (timer > 16'h0001) begin
                  timer <= timer - 16'h0001;
               end else begin
                  O_WE_B <= 1'b1;
                  if (step == last_step(op)) begin
                     timer <= 16'(`FVP_WR_CYC);
                     state <= S_RECOVER;
                  end else begin
                     step  <= step + 3'h1;
                     timer <= 16'(`FVP_WPH_CYC);
                     state <= S_WHIGH;
                  end
               end
            end
            S_RECOVER: begin
               // Hold off any read until write recovery has elapsed
               O_DQ_OE_B <= 1'b1;
               if (timer > 16'h0001) begin
                  timer <= timer - 16'h0001;
               end else if (op == fvp_pkg::FVP_OP_PROGRAM) begin
                  O_OE_B <= 1'b0;
                  timer  <= 16'(`FVP_RD_CYC);
                  state  <= S_RDWAIT;
               end else begin
                  state <= S_FIN;
               end
            end
            S_RDWAIT: begin
               // Address is not re-driven meaningfully: flash holds it latched
               if (timer > 16'h0001) begin
                  timer <= timer - 16'h0001;
               end else begin
                  state <= S_CHECK;
               end
            end
            S_CHECK: begin
               O_OE_B <= 1'b1;
               if (dq_sync == word.data) begin
                  state <= S_FIN;
               end else if (tries == `FVP_RETRY_MAX) begin
                  O_FAIL <= 1'b1;
                  state  <= S_FIN;
               end else begin
                  tries <= tries + 8'h01;
                  step  <= 3'h0;
                  timer <= 16'(`FVP_WPH_CYC);
                  state <= S_WHIGH;
               end
            end
            S_FIN: begin
               O_CE_B   <= 1'b1;
               O_VPP_EN <= 1'b0;
               O_BUSY   <= 1'b0;
               O_DONE   <= 1'b1;
               state    <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

endmodule

/* File: tb/fvp_host_sva.sv */
/* Pin-timing checker for the flash host sequencer.
   Assumes one 40 MHz clock domain; bound onto fvp_host below. */
`timescale 1ns/1ps
module fvp_host_chk (
   // Clock and reset
   input wire logic        I_CLK,
   input wire logic        I_RST_B,
   // Flash pins
   input wire logic        O_CE_B,
   input wire logic        O_OE_B,
   input wire logic        O_WE_B,
   input wire logic        O_VPP_EN,
   input wire logic [15:0] O_ADDR,
   input wire logic [15:0] O_DQ,
   input wire logic        O_DQ_OE_B
);
   logic [7:0] rec_cnt;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   // Cycles since the strobe rose; saturates so a long idle stays legal
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rec_cnt <= 8'hFF;
      end else if (!O_WE_B) begin
         rec_cnt <= 8'h00;
      end else if (rec_cnt != 8'hFF) begin
         rec_cnt <= rec_cnt + 8'h01;
      end
   end
   a_write_inhibit: assert property (!O_WE_B |-> !O_CE_B && O_OE_B)
      else $error("write strobe while reading or deselected");
   a_vpp_at_write: assert property ($fell(O_WE_B) |-> O_VPP_EN && !O_DQ_OE_B)
      else $error("write strobe without program supply or data");
   a_bus_held: assert property (!O_WE_B |=> O_WE_B || ($stable(O_ADDR) && $stable(O_DQ)))
      else $error("address or data moved under the strobe");
   a_pulse_width: assert property ($fell(O_WE_B) |=> !O_WE_B ##1 O_WE_B)
      else $error("write pulse not two cycles");
   // The rising sample counts as the first of the four high cycles
   a_high_gap: assert property ($rose(O_WE_B) |-> O_WE_B [*4])
      else $error("write strobe high too short");
   a_read_recov: assert property ($fell(O_OE_B) |-> rec_cnt >= 8'hF0)
      else $error("read started before write recovery");
   a_read_strobes: assert property ($fell(O_OE_B) |-> !O_CE_B && O_WE_B)
      else $error("verify read without chip select");
   a_dq_released: assert property (!O_OE_B |-> O_DQ_OE_B)
      else $error("host drives data during a read");
endmodule
bind fvp_host fvp_host_chk chk_u (
   .I_CLK     (I_CLK),
   .I_RST_B   (I_RST_B),
   .O_CE_B    (O_CE_B),
   .O_OE_B    (O_OE_B),
   .O_WE_B    (O_WE_B),
   .O_VPP_EN  (O_VPP_EN),
   .O_ADDR    (O_ADDR),
   .O_DQ      (O_DQ),
   .O_DQ_OE_B (O_DQ_OE_B)
);

/* File: tb/fvp_flash_model.sv */
/* Behavioural model of the command-driven flash on the far side.
   Assumes the host drives all strobes; the data bus arrives split in and out. */
`timescale 1ns/1ps
module fvp_flash_model (
   // Pins and test controls
   input  wire logic        ce_b, oe_b, we_b, vpp, vcc_ok, corrupt,
   input  wire logic [15:0] addr, din,
   // Read data and observed state
   output logic [15:0]      dout,
   output logic [1:0]       mode,
   output int               n_prog, n_ver, n_abort
);
   logic [15:0] mem [0:65535];
   logic [15:0] lat_a;
   logic        prog_next, last_ff;
   wire logic   wr_ok = vcc_ok && vpp && !ce_b && oe_b;
   // Power-up lands in read mode whatever the supply order
   initial begin
      mode = 2'h0;
      {prog_next, last_ff, n_prog, n_ver, n_abort, lat_a, dout} = '0;
   end
   // Address taken as the strobe falls and kept until the next program data write
   always @(negedge we_b)
      if (wr_ok && prog_next) lat_a = addr;
   // Commands and program data both land as the strobe rises
   always @(posedge we_b)
      if (wr_ok && prog_next) begin
         mem[lat_a] = corrupt ? din ^ 16'h0001 : din;
         prog_next = 1'b0;
         n_prog++;
      end else if (wr_ok) begin
         case (din[7:0])
            8'h40: prog_next = 1'b1;
            8'hC0: begin mode = 2'h2; n_ver++; end
            8'h00: mode = 2'h0;
            8'hFF: if (last_ff) begin mode = 2'h0; n_abort++; end
            default: ;
         endcase
         last_ff = (din[7:0] == 8'hFF) && !last_ff;
      end
   // Deselected, the bus shows the inverse of its last value
   always @(ce_b, oe_b, mode, addr, lat_a)
      if (!ce_b && !oe_b) dout = (mode == 2'h2) ? mem[lat_a] : mem[addr];
      else dout = ~dout;
endmodule

/* File: tb/tb.sv */
/* Self-checking bench for the flash host sequencer against the flash model.
   Assumes fvp_pkg is compiled first; inputs move on falling clock edges. */
`timescale 1ns/1ps
`include "fvp_defines.svh"
module tb;
   logic                  i_clk = 1'b0;
   logic                  i_rst_b = 1'b0;
   logic                  i_req = 1'b0;
   logic                  corrupt = 1'b0;
   logic                  vcc_ok = 1'b1;
   fvp_pkg::fvp_op_type   i_op = fvp_pkg::FVP_OP_READ_MODE;
   fvp_pkg::fvp_word_type i_word = '0;
   logic                  o_busy, o_done, o_fail, o_ce_b, o_oe_b, o_we_b, o_vpp_en, o_dq_oe_b;
   logic [15:0]           o_addr, o_dq, i_dq;
   logic [1:0]            mode;
   int                    n_prog, n_ver, n_abort, fails = 0, checks_done = 0;
   fvp_host dut_u (.I_CLK(i_clk), .I_RST_B(i_rst_b), .I_REQ(i_req), .I_OP(i_op),
      .I_WORD(i_word), .O_BUSY(o_busy), .O_DONE(o_done), .O_FAIL(o_fail), .O_CE_B(o_ce_b),
      .O_OE_B(o_oe_b), .O_WE_B(o_we_b), .O_VPP_EN(o_vpp_en), .O_ADDR(o_addr), .O_DQ(o_dq),
      .O_DQ_OE_B(o_dq_oe_b), .I_DQ(i_dq));
   // The model never sees stale host data when the host has let go
   fvp_flash_model flash_u (.ce_b(o_ce_b), .oe_b(o_oe_b), .we_b(o_we_b), .vpp(o_vpp_en),
      .vcc_ok(vcc_ok), .corrupt(corrupt), .addr(o_addr), .din(o_dq_oe_b ? ~o_dq : o_dq),
      .dout(i_dq), .mode(mode), .n_prog(n_prog), .n_ver(n_ver), .n_abort(n_abort));
   initial forever #12.5 i_clk = ~i_clk;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // One request, then a bounded wait for the done pulse
   task automatic run(input fvp_pkg::fvp_op_type op, input logic [15:0] a, d);
      int n;
      @(negedge i_clk);
      i_req = 1'b1;
      i_op = op;
      i_word = {a, d};
      @(negedge i_clk);
      i_req = 1'b0;
      for (n = 0; n < 40000 && o_done !== 1'b1; n++) @(negedge i_clk);
      if (n == 40000) begin
         fails++;
         close_out();
      end
   endtask
   // Pins idle and model in read mode while reset is held
   task automatic t_reset;
      chk("idle pins", 4'hF, {o_ce_b, o_oe_b, o_we_b, o_dq_oe_b});
      chk("idle flags", 4'h0, {o_busy, o_done, o_fail, o_vpp_en});
      chk("power-up mode", 2'h0, mode);
   endtask
   // Two words back to back, one at the top of the address space
   task automatic t_program;
      run(fvp_pkg::FVP_OP_PROGRAM, 16'h0000, 16'hA5C3);
      run(fvp_pkg::FVP_OP_PROGRAM, 16'hFFFF, 16'h0000);
      chk("word 0000", 16'hA5C3, flash_u.mem[16'h0000]);
      chk("word FFFF", 16'h0000, flash_u.mem[16'hFFFF]);
      chk("verifies", 2, n_ver);
      chk("verify mode", 2'h2, mode);
      chk("fail flag", 1'b0, o_fail);
   endtask
   // A word that never verifies must be retried, then flagged
   task automatic t_fail;
      corrupt = 1'b1;
      run(fvp_pkg::FVP_OP_PROGRAM, 16'h1234, 16'h5A5A);
      corrupt = 1'b0;
      chk("fail flag", 1'b1, o_fail);
      chk("retried", 32'(2 + `FVP_RETRY_MAX + 1), n_ver);
      chk("verify pairs", n_prog, n_ver);
   endtask
   // Abort taken straight out of verify mode, clearing the old failure
   task automatic t_abort;
      run(fvp_pkg::FVP_OP_ABORT, 16'h0000, 16'h0000);
      chk("abort mode", 2'h0, mode);
      chk("aborts", 1, n_abort);
      chk("fail cleared", 1'b0, o_fail);
      chk("busy after abort", 1'b0, o_busy);
   endtask
   // Read command leaves verify mode, but is ignored while the supply is low
   task automatic t_read_mode;
      run(fvp_pkg::FVP_OP_PROGRAM, 16'h00F0, 16'h0F0F);
      vcc_ok = 1'b0;
      run(fvp_pkg::FVP_OP_READ_MODE, 16'h0000, 16'h0000);
      vcc_ok = 1'b1;
      chk("low supply mode", 2'h2, mode);
      run(fvp_pkg::FVP_OP_READ_MODE, 16'h0000, 16'h0000);
      chk("read mode", 2'h0, mode);
   endtask
   initial begin
      repeat (16) @(negedge i_clk);
      t_reset();
      i_rst_b = 1'b1;
      t_program();
      t_fail();
      t_abort();
      t_read_mode();
      close_out();
   end
endmodule
